// ---- counter_core.sv ----
// sixteen-bit counter with ripple prescaler and edge sync
// assumes control fields on core_clk, pins from outside any domain
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module counter_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // pins
    input wire logic ext_count_clock_pin,
    input wire logic osc_input_pin,
    // registers
    count_regs_if.core rif
);
    logic ext_sel;
    logic ripple0_reg;
    logic ripple1_reg;
    logic ripple2_reg;
    logic presc_out;
    logic presc_meta_reg;
    logic presc_sync_reg;
    logic presc_prev_reg;
    logic raw_meta_reg;
    logic raw_sync_reg;
    logic raw_prev_reg;
    logic [15:0] count_reg;
    logic ovf_reg;
    logic tick;
    logic en;
    logic cnt_mode;
    logic sync_on;
    logic asleep;
    logic src_fall;
    logic src_rise;
    logic [1:0] div_reg;
    logic [1:0] div_next;
    count_core_pkg::arm_state_e arm_reg;

    assign en = rif.control[count_core_pkg::bit_enable];
    assign cnt_mode = rif.control[count_core_pkg::bit_count_src]; // [RL1] [RL6]
    assign sync_on = ~rif.control[count_core_pkg::bit_sync_n];
    assign asleep = rif.control[count_core_pkg::bit_sleep];
    // pin choice by oscillator enable
    assign ext_sel = rif.control[count_core_pkg::bit_osc_en] ? osc_input_pin
                                                             : ext_count_clock_pin; // [RL7]

    // ripple prescaler on raw edges, no system clock involved [RL10] [RL12]
    always_ff @(posedge ext_sel or negedge rst_b) begin
        if (!rst_b) begin
            ripple0_reg <= 1'b0;
        end else begin
            ripple0_reg <= ~ripple0_reg;
        end
    end
    // each later stage toggles on the fall of the one before: an up count
    always_ff @(negedge ripple0_reg or negedge rst_b) begin
        if (!rst_b) begin
            ripple1_reg <= 1'b0;
        end else begin
            ripple1_reg <= ~ripple1_reg;
        end
    end
    always_ff @(negedge ripple1_reg or negedge rst_b) begin
        if (!rst_b) begin
            ripple2_reg <= 1'b0;
        end else begin
            ripple2_reg <= ~ripple2_reg;
        end
    end
    // select 0 bypasses prescaler; ripple bit is a divided copy of the pin
    // changing select while a stage is high passes a false edge: change it idle
    always_comb begin
        case (rif.presc_sel)
            3'h1: presc_out = ripple0_reg;
            3'h2: presc_out = ripple1_reg;
            3'h3: presc_out = ripple2_reg;
            default: presc_out = ext_sel;
        endcase
    end

    // sync after the prescaler [RL8] [RL9]
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_meta_reg <= 1'b0;
            presc_sync_reg <= 1'b0;
            presc_prev_reg <= 1'b0;
        end else begin
            presc_meta_reg <= presc_out;
            presc_sync_reg <= presc_meta_reg;
            presc_prev_reg <= presc_sync_reg;
        end
    end
    // raw pin sync, used only to see the first falling edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            raw_meta_reg <= 1'b0;
            raw_sync_reg <= 1'b0;
            raw_prev_reg <= 1'b0;
        end else begin
            raw_meta_reg <= ext_sel;
            raw_sync_reg <= raw_meta_reg;
            raw_prev_reg <= raw_sync_reg;
        end
    end
    // async mode still passes through sync here: two flops, so edges are seen late
    assign src_rise = presc_sync_reg & ~presc_prev_reg; // [RL4]
    assign src_fall = ~raw_sync_reg & raw_prev_reg;

    // first falling edge arms counting [RL5]
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_reg <= count_core_pkg::arm_wait_low;
        end else begin
            case (arm_reg)
                count_core_pkg::arm_wait_low: begin
                    if (en && cnt_mode && src_fall) begin
                        arm_reg <= count_core_pkg::arm_counting;
                    end
                end
                count_core_pkg::arm_counting: begin
                    if (!en || !cnt_mode) begin
                        arm_reg <= count_core_pkg::arm_wait_low;
                    end
                end
                default: arm_reg <= count_core_pkg::arm_wait_low;
            endcase
        end
    end

    // fosc/4 divider: core clock stands in for fosc [RL2]
    assign div_next = div_reg + 2'h1;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    always_comb begin
        if (!cnt_mode) begin
            tick = (div_reg == 2'(count_core_pkg::fosc_div - 1)); // [RL1] [RL2] [RL3]
        end else if (sync_on && asleep) begin
            tick = 1'b0; // [RL11]
        end else begin
            tick = src_rise && (arm_reg == count_core_pkg::arm_counting); // [RL5]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= count_core_pkg::count_reset;
            ovf_reg <= 1'b0;
        end else begin
            ovf_reg <= 1'b0;
            if (rif.wr_count_stb) begin
                count_reg <= rif.wr_count;
            end else if (en && tick) begin // [RL14]
                count_reg <= count_reg + 16'h0001; // [RL13]
                ovf_reg <= (count_reg == 16'hFFFF); // [RL13]
            end
        end
    end
    assign rif.count = count_reg;
    assign rif.ovf_pulse = ovf_reg;
endmodule : counter_core

// ---- count_core_pkg.sv ----
// constants shared by the event counter/timer and its register slave
// assumes one 100 MHz core clock and an avalon-mm master of 32-bit words
package count_core_pkg;
    localparam int unsigned clk_period_ns = 10;
    localparam int unsigned fosc_div = 4;
    localparam logic [3:0] off_control = 4'h0;
    localparam logic [3:0] off_count = 4'h4;
    localparam logic [3:0] off_status = 4'h8;
    localparam logic [3:0] off_int_clear = 4'hC;
    localparam logic [3:0] off_int_enable = 4'h0;
    localparam logic [3:0] off_prescale = 4'h0;
    localparam int unsigned bit_enable = 0;
    localparam int unsigned bit_count_src = 1;
    localparam int unsigned bit_sync_n = 2;
    localparam int unsigned bit_osc_en = 3;
    localparam int unsigned bit_sleep = 4;
    localparam int unsigned bit_ovf = 0;
    localparam logic [4:0] control_reset = 5'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam int unsigned presc_w = 3;
    localparam logic [2:0] presc_sel_reset = 3'h0;
    localparam int unsigned word_base = 2;
    localparam logic [7:0] reg_int_enable = 8'h10;
    localparam logic [7:0] reg_presc = 8'h14;
    typedef enum logic [1:0] {
        arm_wait_low = 2'b00,
        arm_wait_rise = 2'b01,
        arm_counting = 2'b10
    } arm_state_e;
endpackage : count_core_pkg

// ---- count_regs_if.sv ----
// carrier between the register slave and the counter core
// assumes both ends on core_clk
`timescale 1ns/1ps
interface count_regs_if;
    logic [4:0] control;
    logic [2:0] presc_sel;
    logic [15:0] wr_count;
    logic wr_count_stb;
    logic [15:0] count;
    logic ovf_pulse;
    modport core (input control, input presc_sel, input wr_count, input wr_count_stb,
        output count, output ovf_pulse);
    modport regs (output control, output presc_sel, output wr_count, output wr_count_stb,
        input count, input ovf_pulse);
endinterface : count_regs_if

// ---- external_event_counter_timer.sv ----
// avalon-mm register slave and top of the event counter/timer
// assumes a single core clock and pins asynchronous to it
`timescale 1ns/1ps
// Contract
// RL1: select bit clear means internal timer mode
// RL2: timer mode counts core clock divided four
// RL3: sync bit ignored in timer mode
// RL4: external counting on rising edges only
// RL5: first falling edge needed before counting
// RL6: select bit set means counter mode
// RL7: oscillator enable picks oscillator input pin
// RL8: sync bit clear synchronizes external input
// RL9: synchronizer sits after the prescaler
// RL10: prescaler is asynchronous ripple counter
// RL11: synced counter holds during sleep
// RL12: prescaler keeps counting during sleep
// RL13: sixteen bit wrap sets cleared overflow flag
// RL14: counter advances only while enabled
module external_event_counter_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pins
    input wire logic ext_count_clock_pin,
    input wire logic osc_input_pin,
    output logic osc_output_pin,
    // interrupt
    output logic irq
);
    count_regs_if rif ();
    logic [4:0] timer_control_reg;
    logic [2:0] presc_sel_reg;
    logic status_reg;
    logic int_enable_reg;
    logic [31:0] avs_readdata_reg;
    logic ack_reg;
    logic access;
    logic wr_hit;
    logic clr_ovf;

    counter_core u_core (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ext_count_clock_pin(ext_count_clock_pin),
        .osc_input_pin(osc_input_pin),
        .rif(rif)
    );

    // one wait cycle keeps read data registered
    assign access = (avs_read | avs_write) & ~ack_reg;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_hit = avs_write & ack_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_control_reg <= count_core_pkg::control_reset;
            presc_sel_reg <= count_core_pkg::presc_sel_reset;
            int_enable_reg <= 1'b0;
        end else if (wr_hit) begin
            case (avs_address)
                {4'h0, count_core_pkg::off_control}: timer_control_reg <= avs_writedata[4:0];
                count_core_pkg::reg_int_enable: int_enable_reg <= avs_writedata[0];
                count_core_pkg::reg_presc: presc_sel_reg <= avs_writedata[2:0];
                default: timer_control_reg <= timer_control_reg;
            endcase
        end
    end

    assign clr_ovf = wr_hit && (avs_address == {4'h0, count_core_pkg::off_int_clear})
        && avs_writedata[count_core_pkg::bit_ovf];
    // set beats clear [RL13]
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= 1'b0;
        end else if (rif.ovf_pulse) begin
            status_reg <= 1'b1; // [RL13]
        end else if (clr_ovf) begin
            status_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata_reg <= 32'h00000000;
        end else if (access && avs_read) begin
            case (avs_address)
                {4'h0, count_core_pkg::off_control}: avs_readdata_reg <= {27'h0, timer_control_reg};
                {4'h0, count_core_pkg::off_count}: avs_readdata_reg <= {16'h0, rif.count};
                {4'h0, count_core_pkg::off_status}: avs_readdata_reg <= {31'h0, status_reg};
                count_core_pkg::reg_int_enable: avs_readdata_reg <= {31'h0, int_enable_reg};
                count_core_pkg::reg_presc: avs_readdata_reg <= {29'h0, presc_sel_reg};
                default: avs_readdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign avs_readdata = avs_readdata_reg;

    assign rif.control = timer_control_reg;
    assign rif.presc_sel = presc_sel_reg;
    assign rif.wr_count = avs_writedata[15:0];
    assign rif.wr_count_stb = wr_hit && (avs_address == {4'h0, count_core_pkg::off_count});
    assign irq = status_reg & int_enable_reg;
    // crystal drive stays low: the analog amplifier is outside this logic
    assign osc_output_pin = 1'b0;
endmodule : external_event_counter_timer

// ---- eect_chk.sv ----
// checker on the counter/timer top ports
// assumes it is bound into the top; one clock domain
`timescale 1ns/1ps
module eect_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // pins
    input wire logic osc_output_pin,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic req;
    logic rd_ok;
    assign req = avs_read || avs_write;
    assign rd_ok = avs_read && !avs_waitrequest;
    a_wait_first: assert property ((req && !$past(req)) |-> avs_waitrequest)
        else $error("no wait on new request");
    a_wait_once: assert property ((req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    a_osc_idle: assert property (osc_output_pin == 1'b0)
        else $error("oscillator output driven high");
    a_irq_mask: assert property (
        (avs_write && !avs_waitrequest && avs_address == 8'h10 && !avs_writedata[0]) |=> !irq)
        else $error("irq despite mask");
    a_unmapped_zero: assert property ((rd_ok && avs_address > 8'h14) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_width: assert property (
        (rd_ok && avs_address == 8'h04) |-> avs_readdata[31:16] == 16'h0)
        else $error("count wider than 16 bits");
    a_ctrl_width: assert property (
        (rd_ok && avs_address == 8'h00) |-> avs_readdata[31:5] == 27'h0)
        else $error("control upper bits set");
    a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    c_irq: cover property ($rose(irq));
    c_count_read: cover property (rd_ok && avs_address == 8'h04);
    c_clear: cover property (avs_write && !avs_waitrequest && avs_address == 8'h0C);
endmodule : eect_chk
bind external_event_counter_timer eect_chk eect_chk_i (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_output_pin(osc_output_pin), .irq(irq));

// ---- ext_src.sv ----
// external clock source and low-power oscillator stand-in
// assumes no relation to the core clock; pins idle low between bursts
`timescale 1ns/1ps
module ext_src (
    // count pins
    output logic ext_count_clock_pin,
    output logic osc_input_pin
);
    initial begin
        ext_count_clock_pin = 1'b0;
        osc_input_pin = 1'b0;
    end
    // rise then fall; slow or quick by half period
    task automatic pulses(input logic sel, input int n, input int half_ns);
        repeat (n) begin
            if (sel) osc_input_pin = 1'b1;
            else ext_count_clock_pin = 1'b1;
            #(half_ns);
            osc_input_pin = 1'b0;
            ext_count_clock_pin = 1'b0;
            #(half_ns);
        end
    endtask : pulses
endmodule : ext_src

// ---- tb.sv ----
// bench for the counter/timer: bus, pin bursts, overflow, interrupt
// assumes ext_src and the bound checker
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_count_clock_pin;
    logic osc_input_pin;
    logic osc_output_pin;
    logic irq;
    logic [31:0] rd;
    logic [31:0] c0;
    logic [31:0] dv;
    logic [4:0] cv;
    int n_fail = 0;
    int comparisons = 0;
    int n;
    always #5 core_clk = ~core_clk;
    external_event_counter_timer external_event_counter_timer_i (.core_clk(core_clk),
        .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_count_clock_pin(ext_count_clock_pin),
        .osc_input_pin(osc_input_pin), .osc_output_pin(osc_output_pin), .irq(irq));
    ext_src ext_src_i (.ext_count_clock_pin(ext_count_clock_pin), .osc_input_pin(osc_input_pin));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    // timer increments expected over a span of core clocks
    function automatic logic [31:0] exp_ticks(input int clocks);
        return 32'(clocks / count_core_pkg::fosc_div);
    endfunction : exp_ticks
    // counted edges: prescaled pulses, less the first rise when not yet armed
    function automatic logic [31:0] exp_edges(input int k, input int p, input bit fresh);
        return 32'((k >> p) - (fresh ? 1 : 0));
    endfunction : exp_edges
    // idle edge at the end so the next request never lands in the same step
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // values read here are those that stood at the edge; the watchdog ends a hang
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : acc
    // 40 core clocks between the two count samples
    task automatic window();
        acc(1'b0, 8'h04, 32'h0);
        c0 = rd;
        repeat (37) @(posedge core_clk);
        acc(1'b0, 8'h04, 32'h0);
        dv = 32'(16'(rd - c0));
    endtask : window
    task automatic burst(input logic sel, input int k);
        acc(1'b0, 8'h04, 32'h0);
        c0 = rd;
        ext_src_i.pulses(sel, k, $urandom_range(60, 25));
        repeat (6) @(posedge core_clk);
        acc(1'b0, 8'h04, 32'h0);
        dv = 32'(16'(rd - c0));
    endtask : burst
    task automatic irq_is(input logic e);
        @(negedge core_clk);
        check("irq", {31'h0, irq}, {31'h0, e});
        @(posedge core_clk);
    endtask : irq_is
    initial begin
        void'($urandom(71));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 32; a += 4) begin
            acc(1'b0, 8'(a), 32'h0);
            check("reset value", rd, 32'h0);
        end
        cv = 5'($urandom()) & 5'h1E;
        acc(1'b1, 8'h00, {27'h0, cv});
        acc(1'b0, 8'h00, 32'h0);
        check("control", rd, {27'h0, cv});
        for (int s = 0; s < 2; s++) begin
            acc(1'b1, 8'h00, 32'(1 + 4 * s));
            window();
            check("timer ticks", dv, exp_ticks(40));
        end
        acc(1'b1, 8'h00, 32'h0);
        window();
        check("held count", dv, 32'h0);
        for (int i = 0; i < 4; i++) begin
            acc(1'b1, 8'h00, 32'h0);
            cv = {1'b0, i[0], ~i[1], 2'b11};
            acc(1'b1, 8'h00, {27'h0, cv});
            burst(!i[0], 5);
            check("other pin", dv, 32'h0);
            n = $urandom_range(12, 2);
            burst(i[0], n);
            check("edges", dv, exp_edges(n, 0, 1'b1));
        end
        // mid-run reset zeroes the ripple stages so prescaled counts are exact
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        acc(1'b0, 8'h04, 32'h0);
        check("count after reset", rd, 32'h0);
        acc(1'b1, 8'h00, 32'h0000000B);
        burst(1'b1, 8);
        check("first edges", dv, exp_edges(8, 0, 1'b1));
        for (int p = 1; p < 4; p++) begin
            acc(1'b1, 8'h14, 32'(p));
            burst(1'b1, 16);
            check("prescaled", dv, exp_edges(16, p, 1'b0));
        end
        acc(1'b1, 8'h00, 32'h0000001B);
        burst(1'b1, 12);
        check("sleep hold", dv, 32'h0);
        // four more pulses end the divide-by-eight period begun in sleep
        acc(1'b1, 8'h00, 32'h0000000B);
        burst(1'b1, 4);
        check("prescaler ran in sleep", dv, 32'h0);
        burst(1'b1, 4);
        check("prescaler after sleep", dv, exp_edges(8, 3, 1'b0));
        acc(1'b1, 8'h00, 32'h0000001F);
        burst(1'b1, 8);
        check("async sleep", dv, exp_edges(8, 3, 1'b0));
        acc(1'b1, 8'h00, 32'h0);
        acc(1'b1, 8'h04, 32'h0000FFFE);
        acc(1'b1, 8'h10, 32'h1);
        acc(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge core_clk);
        acc(1'b1, 8'h00, 32'h0);
        acc(1'b0, 8'h08, 32'h0);
        check("overflow", rd, 32'h1);
        acc(1'b0, 8'h04, 32'h0);
        check("wrapped", {31'h0, rd < 32'h10}, 32'h1);
        irq_is(1'b1);
        acc(1'b1, 8'h10, 32'h0);
        irq_is(1'b0);
        acc(1'b1, 8'h10, 32'h1);
        acc(1'b1, 8'h0C, 32'h1);
        acc(1'b1, 8'h08, 32'h1);
        acc(1'b0, 8'h08, 32'h0);
        check("cleared", rd, 32'h0);
        irq_is(1'b0);
        complete_run();
    end
    initial begin
        #300000;
        n_fail++;
        complete_run();
    end
endmodule : tb
